// File: interval_and_watchdog_timer.sv
// Purpose: 8-bit interval timer feeding a 3-bit watchdog, with stop-mode
//          wake delay, on a classic Wishbone slave
// Assumes: stop_req and wake_req come from logic on clk
// Notes:   a watchdog reset pulses system_reset and resets this block too
//
// Behaviour
// - each interval counter overflow clocks the 3-bit watchdog counter while it is enabled
// - interval counter free-runs, +1 per selected divided tick, no reload
// - one interval is 256 ticks ending in overflow
// - overflow past 255 sets the interval interrupt pending flag
// - on the interrupt the interval counter wraps to zero and continues
// - control bits 3:2 select divide by 2^13, 2^12, 2^11 or 2^9
// - on stop wake, core clock blocked until interval bit 4 overflows
// - reset wake uses 2^13; interrupt wake keeps programmed selection
// - each interval overflow advances watchdog counter by one while enabled
// - watchdog overflow while enabled raises system reset
// - enable field 0xA5 stops watchdog; other values enable it
// - reset clears control register to zero, watchdog enabled
// - writing one to control bit 0 clears watchdog counter
// - writing one to control bit 1 clears interval counter
// - 16-bit read-write control register at index 0xA002, reset zero
// - read-only 8-bit count at index 0xA007, reset zero
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none

module interval_and_watchdog_timer (
   input  wire logic            clk,
   input  wire logic            rst_b,
   input  wire wdt_pkg::wb_req_t wb_req,
   output wdt_pkg::wb_rsp_t     wb_rsp,
   input  wire logic            stop_req,
   input  wire logic            wake_req,
   output logic                 core_clk_en,
   output logic                 system_reset,
   output logic                 irq
);
   import wdt_pkg::*;

   // ************************************************
   // helpers
   // ************************************************
   // word decode: byte lanes [1:0] of the address are ignored
   function automatic logic hit_of(input logic [ADDR_W-1:0] adr,
                                   input logic [15:0]       idx);
      hit_of = adr[ADDR_W-1:2] == idx;
   endfunction

   function automatic logic tick_of(input logic [PRESC_W-1:0] p,
                                    input logic [1:0]         cs);
      logic [PRESC_W-1:0] m;
      m = '1;
      case (cs)
         CS_DIV_8K: m = PRESC_W'((1 << EXP_8K) - 1);
         CS_DIV_4K: m = PRESC_W'((1 << EXP_4K) - 1);
         CS_DIV_2K: m = PRESC_W'((1 << EXP_2K) - 1);
         default:   m = PRESC_W'((1 << EXP_512) - 1);
      endcase
      tick_of = ((p & m) == m);
   endfunction

   // ************************************************
   // declarations
   // ************************************************
   ctrl_t              ctrl;
   logic [7:0]         count_value;
   logic [2:0]         watchdog_count;
   logic [PRESC_W-1:0] presc;
   logic [IRQ_W-1:0]   irq_stat;
   logic [IRQ_W-1:0]   irq_mask;
   run_state_t         state;
   logic               blk_rst;
   logic               req;
   logic               wr;
   logic               hit_ctrl;
   logic               hit_cnt;
   logic               hit_stat;
   logic               hit_mask;
   logic               counting;
   logic               tick;
   logic               interval_ovf;
   logic               wake_ovf;
   logic               wd_enabled;
   logic               wd_ovf;
   logic               watchdog_clear_bit;
   logic               interval_clear_bit;
   logic [IRQ_W-1:0]   irq_set;
   logic [31:0]        next_rdata;

   // block reset: external reset or our own watchdog pulse
   assign blk_rst = !rst_b || system_reset;

   assign req      = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
   assign wr       = req && wb_req.we;
   assign hit_ctrl = hit_of(wb_req.adr, CTRL_IDX);
   assign hit_cnt  = hit_of(wb_req.adr, CNT_IDX);
   assign hit_stat = hit_of(wb_req.adr, IRQ_STAT_IDX);
   assign hit_mask = hit_of(wb_req.adr, IRQ_MASK_IDX);

   // clear strobes exist only during the write cycle, never stored
   assign watchdog_clear_bit = wr && hit_ctrl && wb_req.sel[0]
                               && wb_req.dat[WDT_CLR_BIT];
   assign interval_clear_bit = wr && hit_ctrl && wb_req.sel[0]
                               && wb_req.dat[INT_CLR_BIT];

   // ************************************************
   // power state
   // ************************************************
   // oscillator is off in stop, so divider and counters freeze there
   assign counting = state != ST_STOPPED;

   always_ff @(posedge clk) begin
      if (blk_rst) begin
         state <= ST_WAKING; // reset counts as a wake too
      end else begin
         case (state)
            ST_RUN:     if (stop_req) state <= ST_STOPPED;
            ST_STOPPED: if (wake_req) state <= ST_WAKING;
            ST_WAKING:  if (wake_ovf) state <= ST_RUN;
            default:    state <= ST_WAKING;
         endcase
      end
   end

   assign core_clk_en = state == ST_RUN;

   // ************************************************
   // divider and interval counter
   // ************************************************
   always_ff @(posedge clk) begin
      if (blk_rst) begin
         presc <= PRESC_RST;
      end else if (state == ST_STOPPED && wake_req) begin
         presc <= PRESC_RST;
      end else if (counting) begin
         presc <= presc + PRESC_W'(1);
      end
   end

   // control keeps its selection across stop, so an interrupt wake reuses
   // it while a reset wake sees the cleared default
   assign tick = counting && tick_of(presc, ctrl.clk_sel);

   assign interval_ovf = tick && count_value == 8'hFF;
   assign wake_ovf     = tick && count_value[WAKE_BIT:0] == '1;

   always_ff @(posedge clk) begin
      if (blk_rst) begin
         count_value <= CNT_RST;
      end else if (interval_clear_bit) begin
         count_value <= CNT_RST;
      end else if (state == ST_STOPPED && wake_req) begin
         count_value <= CNT_RST;
      end else if (tick) begin
         count_value <= count_value + 8'h01;
      end
   end

   // ************************************************
   // watchdog counter
   // ************************************************
   assign wd_enabled = ctrl.wd_enable != WDT_OFF_KEY;
   assign wd_ovf     = wd_enabled && interval_ovf
                       && watchdog_count == 3'h7
                       && !watchdog_clear_bit;

   always_ff @(posedge clk) begin
      if (blk_rst) begin
         watchdog_count <= WD_CNT_RST;
      end else if (watchdog_clear_bit) begin
         watchdog_count <= WD_CNT_RST;
      end else if (wd_enabled && interval_ovf) begin
         watchdog_count <= watchdog_count + 3'h1;
      end
   end

   // one-cycle pulse: it resets the block, which removes its own cause
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         system_reset <= 1'b0;
      end else begin
         system_reset <= wd_ovf && !system_reset;
      end
   end

   // ************************************************
   // control register
   // ************************************************
   always_ff @(posedge clk) begin
      if (blk_rst) begin
         ctrl.clk_sel   <= CTRL_RST[CS_LSB+1:CS_LSB];
         ctrl.wd_enable <= CTRL_RST[WATCHDOG_ENABLE_FIELD_LSB+7:WATCHDOG_ENABLE_FIELD_LSB];
      end else if (wr && hit_ctrl) begin
         if (wb_req.sel[0]) begin
            ctrl.clk_sel <= wb_req.dat[CS_LSB+1:CS_LSB];
         end
         if (wb_req.sel[1]) begin
            ctrl.wd_enable <= wb_req.dat[WATCHDOG_ENABLE_FIELD_LSB+7:WATCHDOG_ENABLE_FIELD_LSB];
         end
      end
   end

   // ************************************************
   // interrupt status and mask
   // ************************************************
   always_comb begin
      irq_set               = '0;
      irq_set[IRQ_OVF_BIT]  = interval_ovf;
      irq_set[IRQ_WAKE_BIT] = state == ST_WAKING && wake_ovf;
   end

   // set beats a same-cycle write-one clear
   always_ff @(posedge clk) begin
      if (blk_rst) begin
         irq_stat <= IRQ_RST;
      end else if (wr && hit_stat && wb_req.sel[0]) begin
         irq_stat <= (irq_stat & ~wb_req.dat[IRQ_W-1:0]) | irq_set;
      end else begin
         irq_stat <= irq_stat | irq_set;
      end
   end

   always_ff @(posedge clk) begin
      if (blk_rst) begin
         irq_mask <= IRQ_RST;
      end else if (wr && hit_mask && wb_req.sel[0]) begin
         irq_mask <= wb_req.dat[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (blk_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat & irq_mask);
      end
   end

   // ************************************************
   // bus answer
   // ************************************************
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (hit_ctrl) begin
         // clear strobes and reserved bits read back as zero
         next_rdata[WATCHDOG_ENABLE_FIELD_LSB+7:WATCHDOG_ENABLE_FIELD_LSB] = ctrl.wd_enable;
         next_rdata[CS_LSB+1:CS_LSB]     = ctrl.clk_sel;
      end else if (hit_cnt) begin
         next_rdata[7:0] = count_value;
      end else if (hit_stat) begin
         next_rdata[IRQ_W-1:0] = irq_stat;
      end else if (hit_mask) begin
         next_rdata[IRQ_W-1:0] = irq_mask;
      end
   end

   // fixed one-wait answer; unmapped addresses ack with zero data.
   // ack must survive our own watchdog pulse, so only rst_b clears it
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wb_rsp.ack <= 1'b0;
         wb_rsp.dat <= 32'h0000_0000;
      end else begin
         wb_rsp.ack <= req;
         if (req && !wb_req.we) begin
            wb_rsp.dat <= next_rdata;
         end
      end
   end

endmodule // interval_and_watchdog_timer

`default_nettype wire

// File: interval_and_watchdog_timer_assertions.sv
// Purpose: port-level checks for the interval and watchdog timer
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every instance of the timer
`timescale 1ns/10ps
`default_nettype none

module wdt_checker
   import wdt_pkg::*;
(
   input wire logic    clk,
   input wire logic    rst_b,
   input wire wb_req_t wb_req,
   input wire wb_rsp_t wb_rsp,
   input wire logic    stop_req,
   input wire logic    wake_req,
   input wire logic    core_clk_en,
   input wire logic    system_reset,
   input wire logic    irq
);
   // fastest wake is 32 ticks of 512 cycles
   localparam int WAKE_MIN = 16000;
   // fastest watchdog is 8 x 256 ticks of 512 cycles
   localparam int WD_MIN   = 1000000;

   logic [20:0] low_cnt;
   logic [20:0] run_cnt;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   always_ff @(posedge clk) begin
      low_cnt <= (!rst_b || core_clk_en) ? 21'h0 : low_cnt + 21'h1;
   end

   always_ff @(posedge clk) begin
      run_cnt <= (!rst_b || system_reset) ? 21'h0 : run_cnt + 21'h1;
   end

   sequence s_take;
      wb_req.cyc && wb_req.stb && !wb_rsp.ack;
   endsequence

   sequence s_read_of(logic [15:0] idx);
      wb_rsp.ack && !wb_req.we && wb_req.adr[17:2] == idx;
   endsequence

   sequence s_stop;
      stop_req && core_clk_en;
   endsequence

   a_ack_one_wait: assert property (s_take |=> wb_rsp.ack) else $error("ack late");
   a_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack stuck");
   a_ack_needs_req: assert property (!(wb_req.cyc && wb_req.stb) |=> !wb_rsp.ack) else $error("stray ack");
   a_count_eight_bits: assert property (s_read_of(CNT_IDX) |-> wb_rsp.dat[31:8] == 24'h000000)
      else $error("count too wide");
   a_clear_bits_zero: assert property (s_read_of(CTRL_IDX) |-> wb_rsp.dat[1:0] == 2'b00 && wb_rsp.dat[7:4] == 4'h0)
      else $error("clear bits read set");
   a_reset_single: assert property (system_reset |=> !system_reset) else $error("reset too long");
   a_stop_gates_clk: assert property (s_stop |=> !core_clk_en) else $error("stop ignored");
   a_wake_not_early: assert property ($rose(core_clk_en) |-> low_cnt >= WAKE_MIN)
      else $error("clock released early");
   a_wd_not_early: assert property (system_reset |-> run_cnt >= WD_MIN) else $error("watchdog early");
endmodule // wdt_checker

bind interval_and_watchdog_timer wdt_checker u_wdt_checker (.clk(clk), .rst_b(rst_b), .wb_req(wb_req),
   .wb_rsp(wb_rsp), .stop_req(stop_req), .wake_req(wake_req), .core_clk_en(core_clk_en),
   .system_reset(system_reset), .irq(irq));

`default_nettype wire

// File: interval_and_watchdog_timer_tb.sv
// Purpose: directed bench for the interval and watchdog timer
// Assumes: register index x 4 is the byte address
// Notes:   watchdog expiry needs over a million cycles, left to the checker
`timescale 1ns/10ps
`default_nettype none

module interval_and_watchdog_timer_tb;
   import wdt_pkg::*;

   logic    clk = 1'b0;
   logic    rst_b;
   logic    stop_req;
   logic    wake_req;
   logic    core_clk_en;
   logic    system_reset;
   logic    irq;
   wb_req_t req;
   wb_rsp_t rsp;
   int      errors = 0;
   int      checked = 0;

   always #50 clk = ~clk;

   interval_and_watchdog_timer DUT (.clk(clk), .rst_b(rst_b), .wb_req(req), .wb_rsp(rsp), .stop_req(stop_req),
      .wake_req(wake_req), .core_clk_en(core_clk_en), .system_reset(system_reset), .irq(irq));

   // ************************************************
   // helpers
   // ************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {idx, 2'b00}, sel: 4'hF, dat: wd};
      do begin
         @(posedge clk);
         n++;
      end while (rsp.ack !== 1'b1 && n < 50);
      rd = rsp.dat;
      req.cyc <= 1'b0;
      req.stb <= 1'b0;
      check({31'h0, rsp.ack}, 32'h1, "bus ack");
   endtask

   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, idx, d, x);
   endtask

   task automatic wait_run(output int n);
      n = 0;
      while (core_clk_en !== 1'b1 && n < 40000) begin
         @(posedge clk);
         n++;
      end
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // ************************************************
   // scenarios
   // ************************************************
   task automatic t_reset;
      logic [31:0] v;
      bus(1'b0, CTRL_IDX, 32'h0, v);
      check(v, 32'h0, "ctrl reset");
      wr(CNT_IDX, 32'hFF);
      bus(1'b0, CNT_IDX, 32'h0, v);
      check(v, 32'h0, "count read only");
      wr(16'hA003, 32'hFFFF);
      bus(1'b0, 16'hA003, 32'h0, v);
      check(v, 32'h0, "unmapped read");
      check({31'h0, core_clk_en}, 32'h0, "clock held after reset");
      $display("test reset done");
   endtask

   task automatic t_ctrl;
      logic [31:0] v;
      wr(CTRL_IDX, 32'h0000A50F);
      bus(1'b0, CTRL_IDX, 32'h0, v);
      check(v, 32'h0000A50C, "ctrl readback");
      wr(CTRL_IDX, 32'h0000000C);
      bus(1'b0, CTRL_IDX, 32'h0, v);
      check(v, 32'h0000000C, "ctrl select");
      wr(IRQ_MASK_IDX, 32'h0);
      $display("test ctrl done");
   endtask

   task automatic t_wake;
      logic [31:0] v;
      int          n;
      wait_run(n);
      check({31'h0, core_clk_en}, 32'h1, "clock released");
      bus(1'b0, IRQ_STAT_IDX, 32'h0, v);
      check(v, 32'h2, "wake status");
      check({31'h0, irq}, 32'h0, "masked irq");
      wr(IRQ_MASK_IDX, 32'h2);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h1, "unmasked irq");
      wr(IRQ_STAT_IDX, 32'h2);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0, "cleared irq");
      $display("test wake done");
   endtask

   task automatic t_rates;
      int          exps[4] = '{EXP_8K, EXP_4K, EXP_2K, EXP_512};
      logic [31:0] a;
      logic [31:0] b;
      logic [7:0]  d;
      for (int i = 0; i < 4; i++) begin
         wr(CTRL_IDX, {28'h0, 2'(i), 2'b00});
         bus(1'b0, CNT_IDX, 32'h0, a);
         repeat (2 << exps[i]) @(posedge clk);
         bus(1'b0, CNT_IDX, 32'h0, b);
         d = b[7:0] - a[7:0];
         check({31'h0, d == 8'h02 || d == 8'h03}, 32'h1, "tick rate");
      end
      wr(CTRL_IDX, 32'h0000000E);
      bus(1'b0, CNT_IDX, 32'h0, a);
      check({31'h0, a <= 32'h1}, 32'h1, "interval clear");
      $display("test rates done");
   endtask

   task automatic t_stop;
      logic [31:0] a;
      logic [31:0] b;
      int          n;
      @(posedge clk);
      stop_req <= 1'b1;
      @(posedge clk);
      stop_req <= 1'b0;
      @(posedge clk);
      check({31'h0, core_clk_en}, 32'h0, "stop gates clock");
      bus(1'b0, CNT_IDX, 32'h0, a);
      repeat (1100) @(posedge clk);
      bus(1'b0, CNT_IDX, 32'h0, b);
      check(b, a, "count frozen");
      wake_req <= 1'b1;
      @(posedge clk);
      wake_req <= 1'b0;
      wait_run(n);
      check({31'h0, n > 16300 && n < 16420}, 32'h1, "wake delay");
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h1, "wake irq");
      check({31'h0, system_reset}, 32'h0, "no early watchdog reset");
      $display("test stop done");
   endtask

   initial begin
      rst_b = 1'b0;
      stop_req = 1'b0;
      wake_req = 1'b0;
      req = '0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_ctrl();
      t_wake();
      t_rates();
      t_stop();
      tally_and_finish();
   end

   // bounds a hung handshake or a wake that never ends
   initial begin
      repeat (90000) @(posedge clk);
      errors++;
      $display("watchdog timeout");
      tally_and_finish();
   end
endmodule // interval_and_watchdog_timer_tb

`default_nettype wire

// File: wdt_pkg.sv
// Purpose: shared constants and types for the interval and watchdog timer
// Assumes: 32-bit classic Wishbone, byte address = 4 x register index
// Notes:   register indices are kept as printed
package wdt_pkg;

   // ************************************************
   // bus
   // ************************************************
   localparam int          ADDR_W        = 18;
   localparam logic [15:0] CTRL_IDX      = 16'hA002;
   localparam logic [15:0] CNT_IDX       = 16'hA007;
   localparam logic [15:0] IRQ_STAT_IDX  = 16'hA008;
   localparam logic [15:0] IRQ_MASK_IDX  = 16'hA009;

   // ************************************************
   // control register layout
   // ************************************************
   localparam int          WDT_CLR_BIT   = 0;
   localparam int          INT_CLR_BIT   = 1;
   localparam int          CS_LSB        = 2;
   localparam int          WATCHDOG_ENABLE_FIELD_LSB      = 8;
   localparam logic [15:0] CTRL_RST      = 16'h0000;
   localparam logic [7:0]  WDT_OFF_KEY   = 8'hA5;
   localparam logic [7:0]  CNT_RST       = 8'h00;
   localparam logic [2:0]  WD_CNT_RST    = 3'h0;

   // ************************************************
   // clock select and divider
   // ************************************************
   localparam logic [1:0]  CS_DIV_8K     = 2'b00;
   localparam logic [1:0]  CS_DIV_4K     = 2'b01;
   localparam logic [1:0]  CS_DIV_2K     = 2'b10;
   localparam logic [1:0]  CS_DIV_512    = 2'b11;
   localparam int          EXP_8K        = 13;
   localparam int          EXP_4K        = 12;
   localparam int          EXP_2K        = 11;
   localparam int          EXP_512       = 9;
   localparam int          PRESC_W       = 13;
   localparam logic [12:0] PRESC_RST     = 13'h0000;
   localparam int          WAKE_BIT      = 4;

   // ************************************************
   // interrupt status and mask layout
   // ************************************************
   localparam int          IRQ_W         = 2;
   localparam int          IRQ_OVF_BIT   = 0;
   localparam int          IRQ_WAKE_BIT  = 1;
   localparam logic [1:0]  IRQ_RST       = 2'b00;

   typedef struct packed {
      logic [7:0] wd_enable;
      logic [1:0] clk_sel;
   } ctrl_t;

   typedef struct packed {
      logic              cyc;
      logic              stb;
      logic              we;
      logic [ADDR_W-1:0] adr;
      logic [3:0]        sel;
      logic [31:0]       dat;
   } wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wb_rsp_t;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_STOPPED,
      ST_WAKING
   } run_state_t;

endpackage
